// [uvpb_top.sv]
/*
 * uvpb_top: undervoltage pick-up, blocking, start/trip timing,
 * readouts and event output of one protection stage, APB slave.
 * assumes voltages and block input come from same-clock logic.
 */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module uvpb_top
    import uvpb_pkg::*;
#(
    parameter int CYCLE_CYCLES = CYCLE_CYC,
    parameter int STAMP_CYCLES = STAMP_CYC
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire uvpb_meas_s  i_meas,
    input  wire logic        i_ext_block,
    output logic             o_start,
    output logic             o_trip,
    output logic             o_blocked,
    output logic             o_event_valid,
    output uvpb_event_s      o_event
);
    ////////////////////////////////////////////////////////////////////
    // state
    uvpb_phase_e phase_reg, phase_next;
    logic [31:0] cyc_reg, cyc_next, ms_reg, ms_next, stamp_reg, stamp_next;
    uvpb_meas_s  meas_reg, meas_next;
    logic        blk_s_reg, blk_s_next, uvb_reg, uvb_next, pick_reg, pick_next;
    logic        start_reg, start_next, trip_reg, trip_next, blkd_reg, blkd_next;
    logic [19:0] opc_reg, opc_next;
    logic [4:0]  div_len_reg, div_len_next;
    logic [15:0] relc_reg, relc_next;
    logic [2:0]  pend_reg, pend_next, pon_reg, pon_next;
    logic        evv_reg, evv_next;
    uvpb_event_s ev_reg, ev_next;
    logic [1:0]  ctrl_reg, ctrl_next;
    logic [15:0] pickup_reg, pickup_next, blklvl_reg, blklvl_next;
    logic [19:0] opdly_reg, opdly_next;
    logic [15:0] reldly_reg, reldly_next, vt_reg, vt_next;
    logic [16:0] rat_reg [3];
    logic [16:0] rmin_reg, rmin_next;
    logic [31:0] pickpv_reg, pickpv_next, blkpv_reg, blkpv_next;
    logic [3:0]  brec_reg, brec_next;
    logic [31:0] brts_reg, brts_next;
    uvpb_meas_s  brv_reg, brv_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ready_reg, ready_next, err_reg, err_next;

    logic [15:0] mv [3];
    logic [16:0] rat [3];
    logic [2:0]  done, low, rel, above, below;
    logic        tick, eval, blocking, hit, setup, wr;
    logic [31:0] rd;

    assign mv[0] = meas_reg.a;
    assign mv[1] = meas_reg.b;
    assign mv[2] = meas_reg.c;
    assign tick  = (cyc_reg == 32'(CYCLE_CYCLES - 1));
    assign eval  = (phase_reg == PH_EVAL);

    ////////////////////////////////////////////////////////////////////
    // ratio dividers, one per voltage
    for (genvar g = 0; g < 3; g++) begin : g_div
        uvpb_ratio_div u_div (
            .i_clock   (i_clock),
            .i_reset_n (i_reset_n),
            .i_go      (phase_reg == PH_SAMPLE),
            .i_num     (mv[g]),
            .i_den     (pickup_reg),
            .o_ratio   (rat[g]),
            .o_done    (done[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // program cycle, pick-up and blocking
    always_comb begin
        cyc_next   = tick ? 32'd0 : cyc_reg + 32'd1;
        ms_next    = (ms_reg == 32'(STAMP_CYCLES - 1)) ? 32'd0 : ms_reg + 32'd1;
        stamp_next = (ms_reg == 32'(STAMP_CYCLES - 1)) ? stamp_reg + 32'd1 : stamp_reg;
        phase_next = phase_reg;
        meas_next  = meas_reg;
        blk_s_next = blk_s_reg;
        // cycles spent in the divide phase, for the step checks
        div_len_next = (phase_reg == PH_DIVIDE) ? div_len_reg + 5'd1 : 5'd0;
        for (int i = 0; i < 3; i++) begin
            low[i]   = mv[i] < pickup_reg;
            rel[i]   = 24'(24'(mv[i]) * FULL_PCT) >= 24'(24'(pickup_reg) * RELEASE_PCT);
            above[i] = mv[i] > pickup_reg;
            below[i] = mv[i] < blklvl_reg;
        end
        unique case (phase_reg)
            PH_IDLE: begin
                if (tick) begin
                    meas_next  = i_meas;
                    blk_s_next = ctrl_reg[CTRL_FORCE_EN] ? ctrl_reg[CTRL_FORCE_BLK]
                                                         : i_ext_block;
                    phase_next = PH_SAMPLE;
                end
            end
            PH_SAMPLE: phase_next = PH_DIVIDE;
            PH_DIVIDE: if (done[0]) phase_next = PH_EVAL;
            PH_EVAL:   phase_next = PH_IDLE;
        endcase
        pick_next  = pick_reg;
        uvb_next   = uvb_reg;
        start_next = start_reg;
        trip_next  = trip_reg;
        blkd_next  = blkd_reg;
        opc_next   = opc_reg;
        relc_next  = relc_reg;
        blocking   = 1'b0;
        if (eval) begin
            pick_next = pick_reg ? !(&rel) : (|low);
            if (blklvl_reg == 16'h0000) begin
                uvb_next = 1'b0;
            end else if (|below) begin
                uvb_next = 1'b1;
            end else if (&above) begin
                uvb_next = 1'b0;
            end
            blocking   = blk_s_reg | uvb_next;
            start_next = pick_next & !blocking;
            blkd_next  = blocking & (pick_next | blkd_reg);
            if (start_next) begin
                relc_next = 16'd0;
                if (opc_reg < opdly_reg) opc_next = opc_reg + 20'd1;
            end else if (opc_reg != 20'd0) begin
                // release handling, same for pick-up reset and block
                relc_next = relc_reg + 16'd1;
                if (relc_next >= reldly_reg) begin
                    opc_next  = 20'd0;
                    relc_next = 16'd0;
                end
            end
            trip_next = start_next & (opc_next >= opdly_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readouts, events and block record
    always_comb begin
        rmin_next = rat[0];
        for (int i = 1; i < 3; i++) begin
            if (rat[i] < rmin_next) rmin_next = rat[i];
        end
        if (!done[0]) rmin_next = rmin_reg;
        pickpv_next = 32'(pickup_reg * vt_reg);
        blkpv_next  = 32'(blklvl_reg * vt_reg);
        pend_next   = pend_reg;
        pon_next    = pon_reg;
        evv_next    = 1'b0;
        ev_next     = ev_reg;
        brec_next   = brec_reg;
        brts_next   = brts_reg;
        brv_next    = brv_reg;
        if (eval) begin
            pend_next = pend_reg | ({blkd_next, trip_next, start_next} ^ {blkd_reg, trip_reg, start_reg});
            pon_next  = {blkd_next, trip_next, start_next};
        end else if (pend_reg != 3'b000) begin
            evv_next = 1'b1;
            for (int k = 2; k >= 0; k--) begin
                if (pend_reg[k]) begin
                    ev_next   = '{kind: uvpb_evkind_e'(k[1:0]), on: pon_reg[k], stamp: stamp_reg};
                    pend_next = pend_reg & ~(3'b001 << k);
                end
            end
        end
        if (wr && i_paddr == OFS_BREC && i_pwdata[BREC_FLAG]) brec_next[BREC_FLAG] = 1'b0;
        if (eval && blkd_next && !blkd_reg) begin
            brec_next = {low, 1'b1};
            brts_next = stamp_reg;
            brv_next  = meas_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave, one cycle access phase
    assign setup = i_psel & !i_penable;
    assign wr    = i_psel & i_penable & ready_reg & i_pwrite & !err_reg;

    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        unique case (i_paddr)
            OFS_CTRL:    rd = 32'(ctrl_reg);
            OFS_PICKUP:  rd = 32'(pickup_reg);
            OFS_BLKLVL:  rd = 32'(blklvl_reg);
            OFS_OPDLY:   rd = 32'(opdly_reg);
            OFS_RELDLY:  rd = 32'(reldly_reg);
            OFS_VTSCALE: rd = 32'(vt_reg);
            OFS_STATUS:  rd = 32'({blk_s_reg, uvb_reg, pick_reg, blkd_reg, trip_reg, start_reg});
            OFS_RATIO_A: rd = 32'(rat_reg[0]);
            OFS_RATIO_B: rd = 32'(rat_reg[1]);
            OFS_RATIO_C: rd = 32'(rat_reg[2]);
            OFS_RATIO_M: rd = 32'(rmin_reg);
            OFS_REMAIN:  rd = 32'($signed({1'b0, opdly_reg} - {1'b0, opc_reg}));
            OFS_EXPECT:  rd = 32'(opdly_reg);
            OFS_PICK_PV: rd = pickpv_reg;
            OFS_BLK_PV:  rd = blkpv_reg;
            OFS_BREC:    rd = 32'(brec_reg);
            OFS_BREC_TS: rd = brts_reg;
            OFS_BREC_AB: rd = {brv_reg.a, brv_reg.b};
            OFS_BREC_C:  rd = 32'(brv_reg.c);
            default:     hit = 1'b0;
        endcase
        ready_next  = setup;
        err_next    = setup & !hit;
        rdata_next  = setup ? rd : 32'h0000_0000;
        ctrl_next   = ctrl_reg;
        pickup_next = pickup_reg;
        blklvl_next = blklvl_reg;
        opdly_next  = opdly_reg;
        reldly_next = reldly_reg;
        vt_next     = vt_reg;
        if (wr) begin
            unique case (i_paddr)
                OFS_CTRL:    ctrl_next   = i_pwdata[1:0];
                OFS_PICKUP:  pickup_next = i_pwdata[15:0];
                OFS_BLKLVL:  blklvl_next = i_pwdata[15:0];
                OFS_OPDLY:   opdly_next  = i_pwdata[19:0];
                OFS_RELDLY:  reldly_next = i_pwdata[15:0];
                OFS_VTSCALE: vt_next     = i_pwdata[15:0];
                default:     ctrl_next   = ctrl_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            phase_reg  <= PH_IDLE;
            cyc_reg    <= 32'd0;
            ms_reg     <= 32'd0;
            stamp_reg  <= 32'd0;
            meas_reg   <= '0;
            blk_s_reg  <= 1'b0;
            div_len_reg <= 5'd0;
            uvb_reg    <= 1'b0;
            pick_reg   <= 1'b0;
            start_reg  <= 1'b0;
            trip_reg   <= 1'b0;
            blkd_reg   <= 1'b0;
            opc_reg    <= 20'd0;
            relc_reg   <= 16'd0;
            pend_reg   <= 3'b000;
            pon_reg    <= 3'b000;
            evv_reg    <= 1'b0;
            ev_reg     <= '0;
            ctrl_reg   <= 2'b00;
            pickup_reg <= PICKUP_RST;
            blklvl_reg <= BLKLVL_RST;
            opdly_reg  <= OPDLY_RST;
            reldly_reg <= RELDLY_RST;
            vt_reg     <= VTSCALE_RST;
            rat_reg    <= '{default: 17'd0};
            rmin_reg   <= 17'd0;
            pickpv_reg <= 32'd0;
            blkpv_reg  <= 32'd0;
            brec_reg   <= 4'h0;
            brts_reg   <= 32'd0;
            brv_reg    <= '0;
            rdata_reg  <= 32'd0;
            ready_reg  <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            phase_reg  <= phase_next;
            cyc_reg    <= cyc_next;
            ms_reg     <= ms_next;
            stamp_reg  <= stamp_next;
            meas_reg   <= meas_next;
            blk_s_reg  <= blk_s_next;
            div_len_reg <= div_len_next;
            uvb_reg    <= uvb_next;
            pick_reg   <= pick_next;
            start_reg  <= start_next;
            trip_reg   <= trip_next;
            blkd_reg   <= blkd_next;
            opc_reg    <= opc_next;
            relc_reg   <= relc_next;
            pend_reg   <= pend_next;
            pon_reg    <= pon_next;
            evv_reg    <= evv_next;
            ev_reg     <= ev_next;
            ctrl_reg   <= ctrl_next;
            pickup_reg <= pickup_next;
            blklvl_reg <= blklvl_next;
            opdly_reg  <= opdly_next;
            reldly_reg <= reldly_next;
            vt_reg     <= vt_next;
            if (done[0]) rat_reg <= rat;
            rmin_reg   <= rmin_next;
            pickpv_reg <= pickpv_next;
            blkpv_reg  <= blkpv_next;
            brec_reg   <= brec_next;
            brts_reg   <= brts_next;
            brv_reg    <= brv_next;
            rdata_reg  <= rdata_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
        end
    end

    assign o_prdata      = rdata_reg;
    assign o_pready      = ready_reg;
    assign o_pslverr     = err_reg;
    assign o_start       = start_reg;
    assign o_trip        = trip_reg;
    assign o_blocked     = blkd_reg;
    assign o_event_valid = evv_reg;
    assign o_event       = ev_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    sequence s_sample;  phase_reg == PH_SAMPLE; endsequence
    sequence s_divide;
        phase_reg == PH_DIVIDE && div_len_reg == 5'd0 ##24 phase_reg == PH_DIVIDE && div_len_reg == 5'd24;
    endsequence
    sequence s_eval;    phase_reg == PH_EVAL ##1 phase_reg == PH_IDLE; endsequence

    cycle_steps_a:   assert property (phase_reg == PH_IDLE && tick |=> s_sample ##1 s_divide ##1 s_eval)
        else $error("program cycle steps out of order");
    divide_len_a:    assert property (phase_reg == PH_DIVIDE |-> div_len_reg <= 5'd24)
        else $error("ratio divide ran too long");
    block_sample_a:  assert property ($changed(blk_s_reg) |-> $past(phase_reg) == PH_IDLE && $past(tick))
        else $error("block input sampled outside cycle start");
    start_clear_a:   assert property (o_start |-> !o_blocked && !uvb_reg && (phase_reg != PH_IDLE || !blk_s_reg))
        else $error("start while blocked");
    release_ratio_a: assert property ($fell(pick_reg) |-> $past(eval && (&rel)))
        else $error("pick-up released below 103 percent");
    pickup_any_a:    assert property (eval && (|low) |=> pick_reg)
        else $error("low voltage did not pick up");
    uvb_disabled_a:  assert property (blklvl_reg == 16'h0000 && eval |=> !uvb_reg)
        else $error("low-voltage block active at zero level");
    blocked_set_a:   assert property (eval && blk_s_reg && pick_next |=> o_blocked && !o_start)
        else $error("block at pick-up did not give blocked");
    start_drop_a:    assert property (o_start && eval && blk_s_reg |=> !o_start ##1 !o_trip)
        else $error("start held after block");
    trip_delay_a:    assert property ($rose(o_trip) |-> opc_reg >= opdly_reg && o_start)
        else $error("trip before operating delay");
    block_record_a:  assert property ($rose(o_blocked) |-> brec_reg[BREC_FLAG] && brts_reg == $past(stamp_reg))
        else $error("block record missing");

endmodule : uvpb_top

// [uvpb_pkg.sv]
/*
 * uvpb_pkg: constants, register map and carrier types of the
 * undervoltage pick-up and blocking stage.
 * assumes a 100 MHz clock and an APB master with 32-bit data.
 */
package uvpb_pkg;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ   = 100;
    localparam int CYCLE_MS  = 5;
    localparam int STAMP_MS  = 1;
    localparam int CYCLE_CYC = CYCLE_MS * 1000 * CLK_MHZ;
    localparam int STAMP_CYC = STAMP_MS * 1000 * CLK_MHZ;
    localparam int DIV_STEPS = 24;

    ////////////////////////////////////////////////////////////////////
    // fixed-point factors, percent of threshold
    localparam logic [23:0] FULL_PCT    = 24'h00_0064;
    localparam logic [23:0] RELEASE_PCT = 24'h00_0067;
    localparam logic [16:0] RATIO_MAX   = 17'h1_E848;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PICKUP  = 8'h04;
    localparam logic [7:0] OFS_BLKLVL  = 8'h08;
    localparam logic [7:0] OFS_OPDLY   = 8'h0C;
    localparam logic [7:0] OFS_RELDLY  = 8'h10;
    localparam logic [7:0] OFS_VTSCALE = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;
    localparam logic [7:0] OFS_RATIO_A = 8'h1C;
    localparam logic [7:0] OFS_RATIO_B = 8'h20;
    localparam logic [7:0] OFS_RATIO_C = 8'h24;
    localparam logic [7:0] OFS_RATIO_M = 8'h28;
    localparam logic [7:0] OFS_REMAIN  = 8'h2C;
    localparam logic [7:0] OFS_EXPECT  = 8'h30;
    localparam logic [7:0] OFS_PICK_PV = 8'h34;
    localparam logic [7:0] OFS_BLK_PV  = 8'h38;
    localparam logic [7:0] OFS_BREC    = 8'h3C;
    localparam logic [7:0] OFS_BREC_TS = 8'h40;
    localparam logic [7:0] OFS_BREC_AB = 8'h44;
    localparam logic [7:0] OFS_BREC_C  = 8'h48;

    ////////////////////////////////////////////////////////////////////
    // reset values: 60 %, 10 %, 0.040 s, 0.060 s, scale
    localparam logic [15:0] PICKUP_RST  = 16'h1770;
    localparam logic [15:0] BLKLVL_RST  = 16'h03E8;
    localparam logic [19:0] OPDLY_RST   = 20'h0_0008;
    localparam logic [15:0] RELDLY_RST  = 16'h000C;
    localparam logic [15:0] VTSCALE_RST = 16'h0014;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_FORCE_EN  = 0;
    localparam int CTRL_FORCE_BLK = 1;
    localparam int ST_START       = 0;
    localparam int ST_TRIP        = 1;
    localparam int ST_BLOCKED     = 2;
    localparam int ST_PICKUP      = 3;
    localparam int ST_UVBLOCK     = 4;
    localparam int ST_EXTBLOCK    = 5;
    localparam int BREC_FLAG      = 0;
    localparam int BREC_TYPE      = 1;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_DIVIDE = 2'b10,
        PH_EVAL   = 2'b11
    } uvpb_phase_e;

    typedef enum logic [1:0] {
        EV_START   = 2'b00,
        EV_TRIP    = 2'b01,
        EV_BLOCKED = 2'b10
    } uvpb_evkind_e;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } uvpb_meas_s;

    typedef struct packed {
        uvpb_evkind_e kind;
        logic         on;
        logic [31:0]  stamp;
    } uvpb_event_s;

endpackage : uvpb_pkg

// [uvpb_ratio_div.sv]
/*
 * uvpb_ratio_div: serial divider giving num*100/den, saturated.
 * assumes i_num and i_den hold steady while the divide runs.
 */
`timescale 1ns/1ps
module uvpb_ratio_div
    import uvpb_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_go,
    input  wire logic [15:0] i_num,
    input  wire logic [15:0] i_den,
    output logic      [16:0] o_ratio,
    output logic             o_done
);
    logic        busy_reg, busy_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic [23:0] quo_reg, quo_next;
    logic [16:0] rem_reg, rem_next;
    logic [16:0] ratio_reg, ratio_next;
    logic        done_reg, done_next;
    logic [16:0] rem_sh;

    always_comb begin
        busy_next  = busy_reg;
        cnt_next   = cnt_reg;
        quo_next   = quo_reg;
        rem_next   = rem_reg;
        ratio_next = ratio_reg;
        done_next  = 1'b0;
        rem_sh     = {rem_reg[15:0], quo_reg[23]};
        if (i_go) begin
            busy_next = 1'b1;
            cnt_next  = 5'd0;
            quo_next  = 24'(24'(i_num) * FULL_PCT);
            rem_next  = 17'd0;
        end else if (busy_reg) begin
            if (rem_sh >= {1'b0, i_den}) begin
                rem_next = rem_sh - {1'b0, i_den};
                quo_next = {quo_reg[22:0], 1'b1};
            end else begin
                rem_next = rem_sh;
                quo_next = {quo_reg[22:0], 1'b0};
            end
            cnt_next = cnt_reg + 5'd1;
            if (cnt_reg == 5'(DIV_STEPS - 1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                // zero threshold or huge ratio saturates
                if (i_den == 16'h0000 || quo_next > 24'(RATIO_MAX)) begin
                    ratio_next = RATIO_MAX;
                end else begin
                    ratio_next = quo_next[16:0];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            busy_reg  <= 1'b0;
            cnt_reg   <= 5'd0;
            quo_reg   <= 24'h00_0000;
            rem_reg   <= 17'h0_0000;
            ratio_reg <= 17'h0_0000;
            done_reg  <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            cnt_reg   <= cnt_next;
            quo_reg   <= quo_next;
            rem_reg   <= rem_next;
            ratio_reg <= ratio_next;
            done_reg  <= done_next;
        end
    end

    assign o_ratio = ratio_reg;
    assign o_done  = done_reg;

endmodule : uvpb_ratio_div

// [uvpb_vt_src.sv]
/* uvpb_vt_src: model of the voltage channels and the external block input.
   assumes the bench sets the wanted values well before each tick. */
`timescale 1ns/1ps
module uvpb_vt_src
    import uvpb_pkg::*;
(
    input  wire logic       i_clock,
    input  wire uvpb_meas_s i_want,
    input  wire logic       i_want_blk,
    output uvpb_meas_s      o_meas,
    output logic            o_ext_block
);
    always_ff @(posedge i_clock) begin
        o_meas      <= i_want;
        o_ext_block <= i_want_blk;
    end
endmodule : uvpb_vt_src

// [undervoltage_pickup_blocking_bench.sv]
/* bench for uvpb_top: apb reads queue expectations, a watcher compares.
   assumes 64-clock program cycles and register reset values. */
`timescale 1ns/1ps
module undervoltage_pickup_blocking_bench;
    import uvpb_pkg::*;
    logic        i_clock = 0, i_reset_n = 0, psel = 0, pen = 0, pwr = 0, bset = 0, blk, rdy, err;
    logic [7:0]  paddr = 0;
    logic [2:0]  outs, lvl = 0;
    logic        evv;
    uvpb_event_s ev;
    logic [31:0] pwdata = 0, prdata, a;
    uvpb_meas_s  vset = '0, meas;
    logic [65:0] q[$], e;
    int          n_fail = 0, tests_run = 0, n_blk = 0;
    always #5 i_clock = ~i_clock;
    uvpb_vt_src uvpb_vt_src_inst (.i_clock(i_clock), .i_want(vset), .i_want_blk(bset), .o_meas(meas),
        .o_ext_block(blk));
    uvpb_top #(.CYCLE_CYCLES(64), .STAMP_CYCLES(16)) uvpb_top_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(rdy), .o_pslverr(err), .i_meas(meas), .i_ext_block(blk), .o_start(outs[0]), .o_trip(outs[1]),
        .o_blocked(outs[2]), .o_event_valid(evv), .o_event(ev));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1; pwr <= wr; paddr <= ad; pwdata <= d;
        @(posedge i_clock);
        pen <= 1;
        do @(posedge i_clock); while (rdy !== 1'b1);
        psel <= 0; pen <= 0;
        @(posedge i_clock);
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [32:0] exp, input logic [32:0] m);
        q.push_back({m, exp & m});
        apb(0, ad, 0);
    endtask : rd
    task automatic setv(input logic [15:0] va, input logic [15:0] vb, input logic b);
        vset <= '{va, vb, 16'h1B58};
        bset <= b;
        repeat (130) @(posedge i_clock);
    endtask : setv
    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////
    always @(posedge i_clock) begin
        if (psel && pen && rdy === 1'b1 && !pwr) begin
            e = q.pop_front();
            check({err, prdata} & e[65:33], e[32:0]);
            if (paddr == OFS_STATUS) check({30'h0, outs & e[35:33]}, {30'h0, e[2:0]});
        end
        if (evv === 1'b1) begin
            check({32'h0, ev.on}, {32'h0, !lvl[ev.kind]});
            lvl[ev.kind] = !lvl[ev.kind];
            if (ev.kind == EV_BLOCKED) n_blk++;
        end
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(3));
        repeat (10) @(posedge i_clock);
        i_reset_n <= 1;
        @(posedge i_clock);
        rd(OFS_PICKUP, 33'h0_0000_1770, '1);
        rd(8'hFC, 33'h1_0000_0000, '1);
        rd(OFS_PICK_PV, 33'h0_0001_D4C0, '1);
        rd(OFS_REMAIN, {13'h0, OPDLY_RST}, '1);
        rd(OFS_EXPECT, {13'h0, OPDLY_RST}, '1);
        setv(16'h1B58, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h0, 33'h3D);
        setv(16'h1B58, 16'h1388, 0);
        rd(OFS_STATUS, 33'h09, 33'h3D);
        setv(16'h1B58, 16'h17D4, 0);
        rd(OFS_STATUS, 33'h08, 33'h08);
        setv(16'h1B58, 16'h1824, 0);
        rd(OFS_STATUS, 33'h00, 33'h08);
        setv(16'h1B58, 16'h1388, 0);
        setv(16'h1B58, 16'h1388, 1);
        rd(OFS_STATUS, 33'h2C, 33'h2D);
        rd(OFS_BREC, 33'h5, '1);
        rd(OFS_BREC_AB, 33'h0_1B58_1388, '1);
        apb(1, OFS_BREC, 1);
        rd(OFS_BREC, 33'h4, '1);
        setv(16'h1B58, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h00, 33'h25);
        setv(16'h1B58, 16'h1388, 1);
        rd(OFS_STATUS, 33'h0C, 33'h0D);
        setv(16'h01F4, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h1C, 33'h1D);
        setv(16'h1770, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h1C, 33'h1D);
        setv(16'h1771, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h00, 33'h14);
        apb(1, OFS_BLKLVL, 0);
        apb(1, OFS_OPDLY, 0);
        setv(16'h01F4, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h0B, 33'h1F);
        rd(OFS_EXPECT, 33'h0, '1);
        apb(1, OFS_CTRL, 3);
        setv(16'h01F4, 16'h1B58, 0);
        rd(OFS_STATUS, 33'h2C, 33'h2F);
        apb(1, OFS_CTRL, 0);
        for (int i = 0; i < 4; i++) begin
            a = 32'd100 + ($urandom % 32'd6900);
            setv(a[15:0], 16'h1B58, 0);
            rd(OFS_RATIO_A, {1'b0, a * 32'd100 / 32'd6000}, '1);
            rd(OFS_RATIO_M, {1'b0, a * 32'd100 / 32'd6000}, '1);
        end
        check(n_blk, 6);
        tally_and_finish;
    end
endmodule : undervoltage_pickup_blocking_bench
